// [synth_cfg_consts.svh]
// register map addresses, field positions and reset values of the config bank
`ifndef SYNTH_CFG_CONSTS_SVH
`define SYNTH_CFG_CONSTS_SVH
`define ADDR_SERIAL_SETUP   16'h0000
`define ADDR_READ_BUFFER    16'h0004
`define ADDR_REG_UPDATE     16'h0005
`define ADDR_DIFF_DRV       16'h0200
`define ADDR_SE_DRV         16'h0201
`define ADDR_DAC_TRIM_LO    16'h040B
`define ADDR_DAC_TRIM_HI    16'h040C
`define ADDR_SPUR1_CTRL     16'h0500
`define ADDR_SPUR1_MAG      16'h0501
`define ADDR_SPUR1_PH_LO    16'h0503
`define ADDR_SPUR1_PH_HI    16'h0504
`define ADDR_SPUR2_CTRL     16'h0505
`define ADDR_SPUR2_MAG      16'h0506
`define ADDR_SPUR2_PH_LO    16'h0508
`define ADDR_SPUR2_PH_HI    16'h0509
`define BIT_SDO_ACTIVE      0
`define BIT_LSB_FIRST       1
`define BIT_SOFT_RESET      2
`define BIT_LONG_INSTR      3
`define BIT_READ_BUFFER     0
`define BIT_REG_UPDATE      0
`define RST_SERIAL_NIBBLE   4'h8
`define RST_DIFF_DRV        8'h05
`define RST_SE_DRV          8'h00
`define RST_DAC_TRIM_LO     8'hFF
`define RST_DAC_TRIM_HI     8'h01
`define RST_BUFFERED        8'h00
`define RST_ZERO_BYTE       8'h00
`define NUM_BUFFERED        8
`define BUF_IDX_W           3
`define STRAP_W             4
`endif

// [synth_cfg_pkg.sv]
// types shared by the synthesizer config bank and its users
package synth_cfg_pkg;
  // one register access as decoded from the serial frame
  typedef struct packed {
    logic        wr;     // write strobe, one cycle
    logic        rd;     // read strobe, one cycle
    logic [15:0] addr;   // register address
    logic [7:0]  wdata;  // write byte
  } reg_req_t;
  // active settings of one harmonic spur reduction channel
  typedef struct packed {
    logic       enable;    // channel on
    logic       gain_x2;   // amplitude doubled
    logic [3:0] harmonic;  // harmonic number
    logic [7:0] magnitude; // spur magnitude
    logic [8:0] phase;     // spur phase
  } spur_chan_t;
endpackage

// [synth_serial_config_regs.sv]
// serial-port configuration register bank of the frequency synthesizer
`timescale 1ns/10ps
`include "synth_cfg_consts.svh"
//
// Contract
// - buffered writes wait in shadow until update
// - self-clearing registers return to zero alone
// - setup upper nibble mirrors lower nibble
// - long-instruction bit read-only, always one
// - soft reset defaults all but setup register
// - soft reset bit stays until host clears
// - soft reset keeps straps from hard reset
// - bit one picks lsb or msb first
// - return to msb first needs update
// - bit zero selects four or three wire
// - soft reset restores documented default values
// - update bit acts as update, clears itself
// - read buffer bit picks shadow or active
module synth_serial_config_regs (
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  input  wire synth_cfg_pkg::reg_req_t   i_req,
  input  wire logic                      i_io_update,
  input  wire logic [`STRAP_W-1:0]       i_startup_strap_pins,
  output logic [7:0]                     o_rdata,
  output logic                           o_lsb_first,
  output logic                           o_sdo_enable,
  output logic                           o_soft_reset,
  output logic                           o_io_update,
  output logic [`STRAP_W-1:0]            o_strap,
  output logic [7:0]                     o_diff_drv,
  output logic [7:0]                     o_se_drv,
  output logic [9:0]                     o_dac_trim,
  output synth_cfg_pkg::spur_chan_t      o_spur_first,
  output synth_cfg_pkg::spur_chan_t      o_spur_second
);

  // mirrored byte of the setup register from its lower nibble
  function automatic logic [7:0] mirror_byte(input logic [3:0] n);
    mirror_byte = {n[0], n[1], n[2], n[3], n};
  endfunction

  // map a buffered address to its slot; valid flag in the top bit
  function automatic logic [`BUF_IDX_W:0] buf_slot(input logic [15:0] a);
    unique case (a)
      `ADDR_SPUR1_CTRL:  buf_slot = {1'b1, 3'h0};
      `ADDR_SPUR1_MAG:   buf_slot = {1'b1, 3'h1};
      `ADDR_SPUR1_PH_LO: buf_slot = {1'b1, 3'h2};
      `ADDR_SPUR1_PH_HI: buf_slot = {1'b1, 3'h3};
      `ADDR_SPUR2_CTRL:  buf_slot = {1'b1, 3'h4};
      `ADDR_SPUR2_MAG:   buf_slot = {1'b1, 3'h5};
      `ADDR_SPUR2_PH_LO: buf_slot = {1'b1, 3'h6};
      `ADDR_SPUR2_PH_HI: buf_slot = {1'b1, 3'h7};
      default:           buf_slot = {1'b0, 3'h0};
    endcase
  endfunction

  logic [7:0]            shadow_q [`NUM_BUFFERED]; // pending buffered values
  logic [7:0]            active_q [`NUM_BUFFERED]; // values in effect
  logic                  soft_q;          // soft reset bit, host-cleared
  logic                  sdo_q;           // four-wire mode select
  logic                  lsb_q;           // bit order in effect
  logic                  msb_pend_q;      // msb-first waits for update
  logic                  rdbuf_q;         // readback of pending values
  logic                  upd_bit_q;       // self-clearing update bit
  logic                  upd_out_q;       // registered update pulse
  logic                  strap_done_q;    // straps caught since hard reset
  logic [`STRAP_W-1:0]   strap_q;         // strap values held
  logic [7:0]            diff_q;          // differential driver register
  logic [7:0]            se_q;            // single-ended driver register
  logic [7:0]            trim_lo_q;       // dac trim low byte
  logic [7:0]            trim_hi_q;       // dac trim high byte
  logic [7:0]            rdata_q;         // read data register
  logic [7:0]            rdata_d;         // read mux result
  logic                  upd_now;         // update from pin or bit
  logic                  wr_setup;        // write to setup register
  logic [`BUF_IDX_W:0]   wslot;           // write slot decode
  logic [`BUF_IDX_W:0]   rslot;           // read slot decode

  assign upd_now  = i_io_update | upd_bit_q;
  assign wr_setup = i_req.wr && (i_req.addr == `ADDR_SERIAL_SETUP);
  assign wslot    = buf_slot(i_req.addr);
  assign rslot    = buf_slot(i_req.addr);

  // setup register: untouched by soft reset, only hard reset clears it
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      soft_q     <= 1'b0;
      sdo_q      <= 1'b0;
      lsb_q      <= 1'b0;
      msb_pend_q <= 1'b0;
    end else begin
      if (wr_setup) begin
        // upper nibble ignored, host sends it as a copy of the lower one
        soft_q <= i_req.wdata[`BIT_SOFT_RESET];
        sdo_q  <= i_req.wdata[`BIT_SDO_ACTIVE];
      end
      // lsb first applies at once; going back to msb waits for update
      if (wr_setup && i_req.wdata[`BIT_LSB_FIRST]) begin
        lsb_q      <= 1'b1;
        msb_pend_q <= 1'b0;
      end else if (wr_setup && lsb_q) begin
        msb_pend_q <= 1'b1;
      end else if (upd_now && msb_pend_q) begin
        lsb_q      <= 1'b0;
        msb_pend_q <= 1'b0;
      end
    end
  end

  // straps sampled once after hard reset release, never by soft reset
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      strap_done_q <= 1'b0;
      strap_q      <= '0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      strap_q      <= i_startup_strap_pins;
    end
  end

  // self-clearing update bit; a held soft reset swallows it
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      upd_bit_q <= 1'b0;
    end else if (soft_q) begin
      upd_bit_q <= 1'b0;
    end else begin
      // set for one cycle only, then back to zero by itself
      upd_bit_q <= i_req.wr && (i_req.addr == `ADDR_REG_UPDATE)
                   && i_req.wdata[`BIT_REG_UPDATE];
    end
  end

  // registered copy of the update event for downstream logic
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      upd_out_q <= 1'b0;
    end else begin
      upd_out_q <= upd_now;
    end
  end

  // read buffer select register
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdbuf_q <= 1'b0;
    end else if (soft_q) begin
      rdbuf_q <= 1'b0;
    end else if (i_req.wr && (i_req.addr == `ADDR_READ_BUFFER)) begin
      rdbuf_q <= i_req.wdata[`BIT_READ_BUFFER];
    end
  end

  // unbuffered driver and trim registers; soft reset holds defaults
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      diff_q    <= `RST_DIFF_DRV;
      se_q      <= `RST_SE_DRV;
      trim_lo_q <= `RST_DAC_TRIM_LO;
      trim_hi_q <= `RST_DAC_TRIM_HI;
    end else if (soft_q) begin
      diff_q    <= `RST_DIFF_DRV;
      se_q      <= `RST_SE_DRV;
      trim_lo_q <= `RST_DAC_TRIM_LO;
      trim_hi_q <= `RST_DAC_TRIM_HI;
    end else if (i_req.wr) begin
      unique case (i_req.addr)
        `ADDR_DIFF_DRV:    diff_q    <= i_req.wdata;
        `ADDR_SE_DRV:      se_q      <= i_req.wdata;
        `ADDR_DAC_TRIM_LO: trim_lo_q <= i_req.wdata;
        `ADDR_DAC_TRIM_HI: trim_hi_q <= i_req.wdata;
        default: ;
      endcase
    end
  end

  // shadow copies take host writes directly
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < `NUM_BUFFERED; i++) shadow_q[i] <= `RST_BUFFERED;
    end else if (soft_q) begin
      for (int i = 0; i < `NUM_BUFFERED; i++) shadow_q[i] <= `RST_BUFFERED;
    end else if (i_req.wr && wslot[`BUF_IDX_W]) begin
      shadow_q[wslot[`BUF_IDX_W-1:0]] <= i_req.wdata;
    end
  end

  // active copies move only on an update or a soft reset; a same-cycle write waits
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      for (int i = 0; i < `NUM_BUFFERED; i++) active_q[i] <= `RST_BUFFERED;
    end else if (soft_q) begin
      for (int i = 0; i < `NUM_BUFFERED; i++) active_q[i] <= `RST_BUFFERED;
    end else if (upd_now) begin
      for (int i = 0; i < `NUM_BUFFERED; i++) active_q[i] <= shadow_q[i];
    end
  end

  // readback mux; unmapped and reserved addresses read zero
  always_comb begin
    rdata_d = `RST_ZERO_BYTE;
    if (rslot[`BUF_IDX_W]) begin
      rdata_d = rdbuf_q ? shadow_q[rslot[`BUF_IDX_W-1:0]]
                        : active_q[rslot[`BUF_IDX_W-1:0]];
    end else begin
      unique case (i_req.addr)
        // long-instruction bit fixed at one, mirrored into bit 4
        `ADDR_SERIAL_SETUP: rdata_d = mirror_byte({1'b1, soft_q, lsb_q, sdo_q});
        `ADDR_READ_BUFFER:  rdata_d = {7'h00, rdbuf_q};
        `ADDR_REG_UPDATE:   rdata_d = {7'h00, upd_bit_q};
        `ADDR_DIFF_DRV:     rdata_d = diff_q;
        `ADDR_SE_DRV:       rdata_d = se_q;
        `ADDR_DAC_TRIM_LO:  rdata_d = trim_lo_q;
        `ADDR_DAC_TRIM_HI:  rdata_d = trim_hi_q;
        default:            rdata_d = `RST_ZERO_BYTE;
      endcase
    end
  end

  // read data held until the next read strobe
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_q <= `RST_ZERO_BYTE;
    end else if (i_req.rd) begin
      rdata_q <= rdata_d;
    end
  end

  // outputs straight from the register flops
  assign o_rdata       = rdata_q;
  assign o_lsb_first   = lsb_q;
  assign o_sdo_enable  = sdo_q;
  assign o_soft_reset  = soft_q;
  assign o_io_update   = upd_out_q;
  assign o_strap       = strap_q;
  assign o_diff_drv    = diff_q;
  assign o_se_drv      = se_q;
  assign o_dac_trim    = {trim_hi_q[1:0], trim_lo_q};
  assign o_spur_first  = {active_q[0][7], active_q[0][6], active_q[0][3:0],
                          active_q[1], active_q[3][0], active_q[2]};
  assign o_spur_second = {active_q[4][7], active_q[4][6], active_q[4][3:0],
                          active_q[5], active_q[7][0], active_q[6]};

  // shadow change never reaches active without an update
  property p_hold_active;
    @(posedge i_clk) disable iff (i_sys_rst)
    !upd_now && !soft_q |=> $stable(active_q[0]) && $stable(active_q[7]);
  endproperty
  a_hold_active: assert property (p_hold_active) else $error("active moved without update");

  // update copies shadow into active
  property p_apply;
    @(posedge i_clk) disable iff (i_sys_rst)
    upd_now && !soft_q |=> active_q[2] == $past(shadow_q[2]);
  endproperty
  a_apply: assert property (p_apply) else $error("update did not apply shadow");

  // update bit lasts exactly one cycle and drives the pulse out
  property p_autoclear;
    @(posedge i_clk) disable iff (i_sys_rst)
    upd_bit_q |=> !upd_bit_q && o_io_update;
  endproperty
  a_autoclear: assert property (p_autoclear) else $error("update bit did not clear");

  // setup readback is mirrored with long bit set
  property p_setup_read;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_req.rd && i_req.addr == `ADDR_SERIAL_SETUP
      |=> o_rdata[3] && o_rdata[4] && o_rdata[7] == o_rdata[0]
          && o_rdata[6] == o_rdata[1] && o_rdata[5] == o_rdata[2];
  endproperty
  a_setup_read: assert property (p_setup_read) else $error("setup readback not mirrored");

  // soft reset pins defaults on the other registers
  property p_soft_default;
    @(posedge i_clk) disable iff (i_sys_rst)
    soft_q |=> o_diff_drv == `RST_DIFF_DRV && o_dac_trim[7:0] == `RST_DAC_TRIM_LO
               && active_q[1] == `RST_BUFFERED;
  endproperty
  a_soft_default: assert property (p_soft_default) else $error("soft reset left a value");

  // soft reset bit stays until a clearing write
  property p_soft_sticky;
    @(posedge i_clk) disable iff (i_sys_rst)
    soft_q && !wr_setup |=> soft_q;
  endproperty
  a_soft_sticky: assert property (p_soft_sticky) else $error("soft reset cleared itself");

  // straps never change once caught
  property p_strap_keep;
    @(posedge i_clk) disable iff (i_sys_rst)
    strap_done_q |=> $stable(o_strap);
  endproperty
  a_strap_keep: assert property (p_strap_keep) else $error("straps resampled");

  // writing lsb first takes effect next cycle
  property p_lsb_now;
    @(posedge i_clk) disable iff (i_sys_rst)
    wr_setup && i_req.wdata[`BIT_LSB_FIRST] |=> o_lsb_first;
  endproperty
  a_lsb_now: assert property (p_lsb_now) else $error("lsb first not applied");

  // msb first only after update
  property p_msb_waits;
    @(posedge i_clk) disable iff (i_sys_rst)
    o_lsb_first && !upd_now |=> o_lsb_first;
  endproperty
  a_msb_waits: assert property (p_msb_waits) else $error("msb first without update");

  // four-wire select follows the written bit
  property p_sdo;
    @(posedge i_clk) disable iff (i_sys_rst)
    wr_setup |=> o_sdo_enable == $past(i_req.wdata[`BIT_SDO_ACTIVE]);
  endproperty
  a_sdo: assert property (p_sdo) else $error("four-wire select wrong");

  // buffered readback follows the read buffer select
  property p_rdbuf;
    @(posedge i_clk) disable iff (i_sys_rst)
    i_req.rd && i_req.addr == `ADDR_SPUR1_MAG
      |=> o_rdata == ($past(rdbuf_q) ? $past(shadow_q[1]) : $past(active_q[1]));
  endproperty
  a_rdbuf: assert property (p_rdbuf) else $error("buffered readback source wrong");

endmodule

// [synth_host_model.sv]
// host controller model driving the pre-decoded register port of the config bank
`timescale 1ns/10ps
`include "synth_cfg_consts.svh"
module synth_host_model (
  input  wire logic               i_clk,
  input  wire logic [7:0]         i_rdata,
  output synth_cfg_pkg::reg_req_t o_req,
  output logic                    o_io_update
);
  // bus idle from time zero
  initial begin
    o_req       = '0;
    o_io_update = 1'b0;
  end

  // one byte write; idle address and data are inverted so stale values never match
  task automatic wr(input logic [15:0] addr, input logic [7:0] data);
    @(negedge i_clk);
    o_req.wr    = 1'b1;
    o_req.addr  = addr;
    o_req.wdata = data;
    @(negedge i_clk);
    o_req.wr    = 1'b0;
    o_req.addr  = ~addr;
    o_req.wdata = ~data;
  endtask

  // setup always sent with the upper nibble copied from the lower one
  task automatic wr_setup(input logic [3:0] lo);
    wr(`ADDR_SERIAL_SETUP, {lo, lo});
  endtask

  // one byte read, data taken in the cycle after the strobe edge
  task automatic rd(input logic [15:0] addr, output logic [7:0] data);
    @(negedge i_clk);
    o_req.rd   = 1'b1;
    o_req.addr = addr;
    @(negedge i_clk);
    o_req.rd   = 1'b0;
    o_req.addr = ~addr;
    data       = i_rdata;
  endtask

  // one-cycle pulse on the update pin
  task automatic update_pin();
    @(negedge i_clk);
    o_io_update = 1'b1;
    @(negedge i_clk);
    o_io_update = 1'b0;
  endtask

  // update through the self-clearing bit; copy lands one cycle after the write
  task automatic update_bit();
    wr(`ADDR_REG_UPDATE, 8'h01);
    @(negedge i_clk);
  endtask
endmodule

// [synth_serial_config_regs_tb.sv]
// self-checking testbench of the serial config register bank
`timescale 1ns/10ps
`include "synth_cfg_consts.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR %0t: value %h expected %h", $time, (got), (exp)); end end
module synth_serial_config_regs_tb;
  logic                      clk;         // 25 MHz bench clock
  logic                      sys_rst;     // hard reset
  synth_cfg_pkg::reg_req_t   req;         // host request
  logic                      io_update;   // update pin
  logic [`STRAP_W-1:0]       strap;       // strap pin levels
  logic [`STRAP_W-1:0]       strap_exp;   // levels at last hard reset
  logic [7:0]                rdata;
  logic                      lsb_first;
  logic                      sdo_enable;
  logic                      soft_reset;
  logic                      upd_q;
  logic [`STRAP_W-1:0]       strap_q;
  logic [7:0]                diff_drv;
  logic [7:0]                se_drv;
  logic [9:0]                dac_trim;
  synth_cfg_pkg::spur_chan_t spur_first;
  synth_cfg_pkg::spur_chan_t spur_second;
  logic [7:0]                rv, a, b, c, d;
  int                        num_errors, n_compared, cycles, seed;

  // setup readback: long-instruction bit forced, upper nibble is the bit-reversed lower one
  function automatic logic [7:0] setup_exp(input logic [3:0] lo);
    logic [3:0] n;
    n = lo | 4'h8;
    return {n[0], n[1], n[2], n[3], n};
  endfunction

  // active spur channel from its four bytes
  function automatic synth_cfg_pkg::spur_chan_t spur_exp(input logic [7:0] ctl, mag, pl, ph);
    return {ctl[7], ctl[6], ctl[3:0], mag, ph[0], pl};
  endfunction

  synth_serial_config_regs synth_serial_config_regs_inst (
    .i_clk(clk), .i_sys_rst(sys_rst), .i_req(req), .i_io_update(io_update),
    .i_startup_strap_pins(strap), .o_rdata(rdata), .o_lsb_first(lsb_first),
    .o_sdo_enable(sdo_enable), .o_soft_reset(soft_reset), .o_io_update(upd_q),
    .o_strap(strap_q), .o_diff_drv(diff_drv), .o_se_drv(se_drv), .o_dac_trim(dac_trim),
    .o_spur_first(spur_first), .o_spur_second(spur_second));

  synth_host_model synth_host_model_inst (
    .i_clk(clk), .i_rdata(rdata), .o_req(req), .o_io_update(io_update));

  // free-running clock
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // hang guard, far above the roughly 130 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  // counts then verdict
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial begin
    num_errors = 0;
    n_compared = 0;
    cycles     = 0;
    seed       = 31999;
    sys_rst    = 1'b1;
    strap      = 4'($random(seed));
    strap_exp  = strap;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    // defaults after hard reset
    synth_host_model_inst.rd(`ADDR_SERIAL_SETUP, rv);
    `CHK(rv, 8'h18)
    `CHK(rv[`BIT_LONG_INSTR], 1'b1)
    `CHK(strap_q, strap_exp)
    `CHK(diff_drv, `RST_DIFF_DRV)
    `CHK(dac_trim, 10'h1FF)
    $display("test defaults done");
    // plain registers with random bytes, unmapped place stays zero
    for (int i = 0; i < 4; i++) begin
      a = $random(seed);
      b = $random(seed);
      c = $random(seed);
      d = $random(seed);
      synth_host_model_inst.wr(`ADDR_DIFF_DRV, a);
      synth_host_model_inst.wr(`ADDR_SE_DRV, b);
      synth_host_model_inst.wr(`ADDR_DAC_TRIM_LO, c);
      synth_host_model_inst.wr(`ADDR_DAC_TRIM_HI, d);
      synth_host_model_inst.wr(16'h0001, a);
      `CHK(diff_drv, a)
      `CHK(se_drv, b)
      `CHK(dac_trim, {d[1:0], c})
      synth_host_model_inst.rd(`ADDR_DIFF_DRV, rv);
      `CHK(rv, a)
      synth_host_model_inst.rd(16'h0001, rv);
      `CHK(rv, 8'h00)
    end
    $display("test plain registers done");
    // buffered channel one through the pin, channel two through the bit
    // magnitude kept nonzero so shadow and active readback always differ
    a = 8'($random(seed)) | 8'h01;
    b = $random(seed);
    c = ($random(seed) & 8'hCF) | 8'h80;
    d = $random(seed) & 8'h01;
    synth_host_model_inst.wr(`ADDR_SPUR1_CTRL, c);
    synth_host_model_inst.wr(`ADDR_SPUR1_MAG, a);
    synth_host_model_inst.wr(`ADDR_SPUR1_PH_LO, b);
    synth_host_model_inst.wr(`ADDR_SPUR1_PH_HI, d);
    `CHK(spur_first, 23'h000000)
    synth_host_model_inst.rd(`ADDR_SPUR1_MAG, rv);
    `CHK(rv, 8'h00)
    synth_host_model_inst.wr(`ADDR_READ_BUFFER, 8'h01);
    synth_host_model_inst.rd(`ADDR_SPUR1_MAG, rv);
    `CHK(rv, a)
    synth_host_model_inst.update_pin();
    `CHK(upd_q, 1'b1)
    `CHK(spur_first, spur_exp(c, a, b, d))
    synth_host_model_inst.wr(`ADDR_SPUR2_CTRL, c ^ 8'h41);
    synth_host_model_inst.wr(`ADDR_SPUR2_MAG, b);
    synth_host_model_inst.wr(`ADDR_SPUR2_PH_LO, a);
    synth_host_model_inst.wr(`ADDR_SPUR2_PH_HI, d ^ 8'h01);
    `CHK(spur_second, 23'h000000)
    synth_host_model_inst.update_bit();
    `CHK(spur_second, spur_exp(c ^ 8'h41, b, a, d ^ 8'h01))
    synth_host_model_inst.rd(`ADDR_REG_UPDATE, rv);
    `CHK(rv, 8'h00)
    $display("test buffered registers done");
    // wire mode and bit order
    synth_host_model_inst.wr_setup(4'h1);
    `CHK(sdo_enable, 1'b1)
    synth_host_model_inst.rd(`ADDR_SERIAL_SETUP, rv);
    `CHK(rv, setup_exp(4'h1))
    synth_host_model_inst.wr_setup(4'h2);
    `CHK(lsb_first, 1'b1)
    `CHK(sdo_enable, 1'b0)
    synth_host_model_inst.wr_setup(4'h0);
    `CHK(lsb_first, 1'b1)
    synth_host_model_inst.update_pin();
    `CHK(lsb_first, 1'b0)
    synth_host_model_inst.rd(`ADDR_SERIAL_SETUP, rv);
    `CHK(rv, 8'h18)
    $display("test serial setup done");
    // soft reset keeps setup and straps, defaults the rest, stays set
    synth_host_model_inst.wr(`ADDR_DIFF_DRV, a | 8'h80);
    synth_host_model_inst.wr_setup(4'h5);
    `CHK(soft_reset, 1'b1)
    // the set bit forces defaults from the following edge on
    @(negedge clk);
    `CHK(sdo_enable, 1'b1)
    `CHK(diff_drv, `RST_DIFF_DRV)
    `CHK(spur_first, 23'h000000)
    synth_host_model_inst.rd(`ADDR_READ_BUFFER, rv);
    `CHK(rv, 8'h00)
    synth_host_model_inst.wr(`ADDR_DIFF_DRV, b | 8'h80);
    `CHK(diff_drv, `RST_DIFF_DRV)
    strap = ~strap_exp;
    repeat (5) @(negedge clk);
    `CHK(soft_reset, 1'b1)
    synth_host_model_inst.rd(`ADDR_SERIAL_SETUP, rv);
    `CHK(rv, setup_exp(4'h5))
    synth_host_model_inst.wr_setup(4'h1);
    `CHK(soft_reset, 1'b0)
    `CHK(diff_drv, `RST_DIFF_DRV)
    `CHK(strap_q, strap_exp)
    $display("test soft reset done");
    // hard reset in mid-run clears the setup register and catches the new strap levels
    synth_host_model_inst.wr_setup(4'h6);
    `CHK(soft_reset, 1'b1)
    `CHK(lsb_first, 1'b1)
    @(negedge clk);
    sys_rst   = 1'b1;
    strap_exp = strap;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    `CHK(strap_q, strap_exp)
    `CHK(soft_reset, 1'b0)
    `CHK(lsb_first, 1'b0)
    synth_host_model_inst.rd(`ADDR_SERIAL_SETUP, rv);
    `CHK(rv, 8'h18)
    $display("test hard reset done");
    wrap_up();
  end
endmodule
